// *** logic/bwsf_host_ctrl.sv ***
// How it works
// - narrow widths: bytes are samples/8, /4, /2
// - buffers sized near 100 ms, larger allowed
// - every used slot address written before start
// - stop at nonzero limit, zero needs host halt
// - code 12 starts, then waits first interrupt
// - start and code 13 block until next-buffer
// - halt code 20 ends a stuck wait
// - refilled buffer index written to release register
// - fill all buffers before start
// - two channels alternate per sample index
// - four channels ordered 0, 2, 1, 3
// - small many buffers for fast update
// - ring quantity between 2 and 256
// - buffer length multiple of 1024 bytes
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`default_nettype none
module bwsf_host_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic dev_req,
   output logic dev_we,
   output logic [15:0] dev_addr,
   output logic [31:0] dev_wdata,
   input wire logic dev_ack,
   input wire logic [31:0] dev_rdata,
   input wire logic dev_next_buf
);
   logic [31:0] slot_addr [256];
   logic [31:0] ring_qty, ring_len, stop_limit, xfer_count, layout, count_cap;
   logic [255:0] filled;
   logic wr_q;
   logic [9:0] wr_idx;
   logic start_pend, start_nowait, await_pend, halt_pend, evt_pend, rel_pend;
   logic [7:0] rel_idx;
   logic done_flag, cfg_err, rel_lost;
   logic ack_m, ack_s, nb_m, nb_s, nb_d;
   logic [31:0] rd_m, rd_s;
   bwsf_pkg::bwsf_state_t state;
   logic [8:0] step;
   logic [1:0] hs_ph;
   logic [31:0] cmd_code;
   logic [15:0] xf_addr;
   logic [31:0] xf_data;
   logic xf_we, xf_active, xfer_done, cfg_ok, all_filled, limit_hit, evt_rise;
   logic wr_ctrl, wr_rel, idle, accept;
   logic [7:0] slot_sel;

   // ----------------------------------------------------------------
   // buffer layout helper
   // ----------------------------------------------------------------
   // query: [31:30] mode, [29:28] channel or width code, [23:0] index
   function automatic logic [31:0] word_offset(input logic [31:0] q);
      logic [23:0] idx;
      logic [1:0] ch;
      idx = q[23:0];
      ch = q[29:28];
      case (q[31:30])
         2'h0: word_offset = {8'h00, idx};
         2'h1: word_offset = {7'h00, idx, ch != 2'h0};
         2'h2: word_offset = {6'h00, idx, ch[0], ch[1]};
         default:
         begin
            // byte count of a narrow single-channel buffer
            case (ch)
               2'h0: word_offset = {11'h000, idx[23:3]};
               2'h1: word_offset = {10'h000, idx[23:2]};
               2'h2: word_offset = {9'h000, idx[23:1]};
               default: word_offset = {8'h00, idx};
            endcase
         end
      endcase
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ack_m <= 1'b0;
         ack_s <= 1'b0;
         nb_m <= 1'b0;
         nb_s <= 1'b0;
         nb_d <= 1'b0;
         rd_m <= 32'h00000000;
         rd_s <= 32'h00000000;
      end
      else
      begin
         ack_m <= dev_ack;
         ack_s <= ack_m;
         nb_m <= dev_next_buf;
         nb_s <= nb_m;
         nb_d <= nb_s;
         rd_m <= dev_rdata;
         rd_s <= rd_m;
      end
   end

   assign evt_rise = nb_s & ~nb_d;
   assign idle = state == bwsf_pkg::S_IDLE;

   // ----------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         wr_q <= 1'b0;
         wr_idx <= 10'h000;
      end
      else
      begin
         wr_q <= hsel && hready && htrans[1] && hwrite;
         wr_idx <= haddr[11:2];
         if (hsel && hready && htrans[1] && !hwrite)
         begin
            if (haddr[11:10] == bwsf_pkg::A_SLOT_PAGE)
               hrdata <= slot_addr[haddr[9:2]];
            else
               case (haddr[11:2])
                  bwsf_pkg::A_STATUS: hrdata <= {26'h0000000, rel_lost, cfg_err, done_flag,
                     state == bwsf_pkg::S_RUN, state == bwsf_pkg::S_WAIT, !idle};
                  bwsf_pkg::A_QTY: hrdata <= ring_qty;
                  bwsf_pkg::A_LEN: hrdata <= ring_len;
                  bwsf_pkg::A_LIMIT: hrdata <= stop_limit;
                  bwsf_pkg::A_COUNT: hrdata <= xfer_count;
                  bwsf_pkg::A_LAYOUT: hrdata <= layout;
                  bwsf_pkg::A_LAYOUT_OFF: hrdata <= word_offset(layout);
                  default: hrdata <= 32'h00000000;
               endcase
         end
      end
   end

   assign wr_ctrl = wr_q && wr_idx == bwsf_pkg::A_CTRL;
   assign wr_rel = wr_q && wr_idx == bwsf_pkg::A_RELEASE;

   // ring geometry is locked while a stream is active
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ring_qty <= bwsf_pkg::QTY_RST;
         ring_len <= bwsf_pkg::LEN_RST;
         stop_limit <= bwsf_pkg::LIMIT_RST;
         layout <= 32'h00000000;
      end
      else
      begin
         if (wr_q && idle && wr_idx == bwsf_pkg::A_QTY)
            ring_qty <= hwdata;
         if (wr_q && idle && wr_idx == bwsf_pkg::A_LEN)
            ring_len <= hwdata;
         if (wr_q && idle && wr_idx == bwsf_pkg::A_LIMIT)
            stop_limit <= hwdata;
         if (wr_q && wr_idx == bwsf_pkg::A_LAYOUT)
            layout <= hwdata;
      end
   end

   // slot table is plain memory, no reset
   always_ff @(posedge hclk)
   begin
      if (wr_q && idle && wr_idx[9:8] == bwsf_pkg::A_SLOT_PAGE)
         slot_addr[wr_idx[7:0]] <= hwdata;
   end

   // ----------------------------------------------------------------
   // pending orders: a set always wins over the clear
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         start_pend <= 1'b0;
         start_nowait <= 1'b0;
         await_pend <= 1'b0;
         halt_pend <= 1'b0;
         evt_pend <= 1'b0;
         rel_pend <= 1'b0;
         rel_idx <= 8'h00;
         rel_lost <= 1'b0;
      end
      else
      begin
         start_pend <= (start_pend & ~idle) | (wr_ctrl & idle &
            (hwdata[bwsf_pkg::CTRL_START_BLOCK] | hwdata[bwsf_pkg::CTRL_START_NOWAIT]));
         if (wr_ctrl && idle)
            start_nowait <= hwdata[bwsf_pkg::CTRL_START_NOWAIT];
         await_pend <= (await_pend & ~(idle | (state == bwsf_pkg::S_RUN & ~halt_pend &
            ~evt_pend))) | (wr_ctrl & ~idle & hwdata[bwsf_pkg::CTRL_AWAIT]);
         halt_pend <= (halt_pend & ~(idle | state == bwsf_pkg::S_WAIT |
            state == bwsf_pkg::S_RUN)) | (wr_ctrl & hwdata[bwsf_pkg::CTRL_HALT]);
         evt_pend <= (evt_pend & ~(idle | ((state == bwsf_pkg::S_WAIT |
            state == bwsf_pkg::S_RUN) & ~halt_pend))) | evt_rise;
         rel_pend <= (rel_pend & ~(idle | (state == bwsf_pkg::S_RUN & ~halt_pend &
            ~evt_pend & ~await_pend))) | (wr_rel & ~idle);
         if (wr_rel && !idle && !rel_pend)
            rel_idx <= hwdata[7:0];
         if (accept)
            rel_lost <= 1'b0;
         else if (wr_rel && !idle && rel_pend)
            rel_lost <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // start checks
   // ----------------------------------------------------------------
   always_comb
   begin
      all_filled = 1'b1;
      for (int i = 0; i < 256; i++)
         if (i < ring_qty && !filled[i])
            all_filled = 1'b0;
   end

   assign cfg_ok = ring_qty >= bwsf_pkg::QTY_MIN && ring_qty <= bwsf_pkg::QTY_MAX &&
      ring_len != 32'h00000000 && ring_len[bwsf_pkg::LEN_ALIGN_BITS-1:0] == 0 &&
      all_filled;
   assign accept = idle && start_pend && cfg_ok;
   assign limit_hit = stop_limit != 32'h00000000 && count_cap >= stop_limit;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         filled <= '0;
         done_flag <= 1'b0;
         cfg_err <= 1'b0;
      end
      else
      begin
         // release writes before start mark buffers as filled
         if (accept)
            filled <= '0;
         // a release in the accepting cycle still counts for the next start
         if (wr_rel)
            filled[hwdata[7:0]] <= 1'b1;
         if (accept)
            cfg_err <= 1'b0;
         else if (idle && start_pend)
            cfg_err <= 1'b1;
         if (accept)
            done_flag <= 1'b0;
         else if (state == bwsf_pkg::S_COUNT && xfer_done && limit_hit)
            done_flag <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // device register access, four-phase handshake
   // ----------------------------------------------------------------
   assign slot_sel = 8'(step - 9'h003);

   always_comb
   begin
      xf_addr = bwsf_pkg::DEV_CMD_REG;
      xf_data = cmd_code;
      xf_we = 1'b1;
      case (state)
         bwsf_pkg::S_SETUP:
         begin
            case (step)
               9'h000:
               begin
                  xf_addr = bwsf_pkg::DEV_QTY_REG;
                  xf_data = ring_qty;
               end
               9'h001:
               begin
                  xf_addr = bwsf_pkg::DEV_LEN_REG;
                  xf_data = ring_len;
               end
               9'h002:
               begin
                  xf_addr = bwsf_pkg::DEV_LIMIT_REG;
                  xf_data = stop_limit;
               end
               default:
               begin
                  xf_addr = 16'(bwsf_pkg::DEV_SLOT_BASE + {8'h00, slot_sel});
                  xf_data = slot_addr[slot_sel];
               end
            endcase
         end
         bwsf_pkg::S_COUNT:
         begin
            xf_addr = bwsf_pkg::DEV_COUNT_REG;
            xf_data = 32'h00000000;
            xf_we = 1'b0;
         end
         bwsf_pkg::S_RELEASE:
         begin
            xf_addr = bwsf_pkg::DEV_RELEASE_REG;
            xf_data = {24'h000000, rel_idx};
         end
         default:
         begin
            xf_we = 1'b1;
         end
      endcase
   end

   assign xf_active = state == bwsf_pkg::S_SETUP || state == bwsf_pkg::S_CMD ||
      state == bwsf_pkg::S_COUNT || state == bwsf_pkg::S_RELEASE;
   assign xfer_done = hs_ph == 2'h2 && !ack_s;

   // request and address stay put until the device acknowledges
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hs_ph <= 2'h0;
         dev_req <= 1'b0;
         dev_we <= 1'b0;
         dev_addr <= 16'h0000;
         dev_wdata <= 32'h00000000;
         count_cap <= 32'h00000000;
      end
      else
      begin
         case (hs_ph)
            2'h0:
            begin
               if (xf_active)
               begin
                  dev_req <= 1'b1;
                  dev_we <= xf_we;
                  dev_addr <= xf_addr;
                  dev_wdata <= xf_data;
                  hs_ph <= 2'h1;
               end
            end
            2'h1:
            begin
               if (ack_s)
               begin
                  dev_req <= 1'b0;
                  count_cap <= rd_s;
                  hs_ph <= 2'h2;
               end
            end
            default:
            begin
               if (!ack_s)
                  hs_ph <= 2'h0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // stream sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= bwsf_pkg::S_IDLE;
         step <= 9'h000;
         cmd_code <= bwsf_pkg::CMD_HALT;
         xfer_count <= 32'h00000000;
      end
      else
      begin
         case (state)
            bwsf_pkg::S_IDLE:
            begin
               if (accept)
               begin
                  state <= bwsf_pkg::S_SETUP;
                  step <= 9'h000;
                  xfer_count <= 32'h00000000;
                  cmd_code <= start_nowait ? bwsf_pkg::CMD_START_NOWAIT :
                     bwsf_pkg::CMD_START_BLOCK;
               end
            end
            bwsf_pkg::S_SETUP:
            begin
               if (xfer_done)
               begin
                  if (step == ring_qty[8:0] + 9'h002)
                     state <= bwsf_pkg::S_CMD;
                  else
                     step <= step + 9'h001;
               end
            end
            bwsf_pkg::S_CMD:
            begin
               if (xfer_done)
               begin
                  if (cmd_code == bwsf_pkg::CMD_START_BLOCK || cmd_code == bwsf_pkg::CMD_AWAIT)
                     state <= bwsf_pkg::S_WAIT;
                  else if (cmd_code == bwsf_pkg::CMD_HALT)
                     state <= bwsf_pkg::S_IDLE;
                  else
                     state <= bwsf_pkg::S_RUN;
               end
            end
            bwsf_pkg::S_WAIT:
            begin
               if (halt_pend)
               begin
                  state <= bwsf_pkg::S_CMD;
                  cmd_code <= bwsf_pkg::CMD_HALT;
               end
               else if (evt_pend)
                  state <= bwsf_pkg::S_COUNT;
            end
            bwsf_pkg::S_RUN:
            begin
               if (halt_pend)
               begin
                  state <= bwsf_pkg::S_CMD;
                  cmd_code <= bwsf_pkg::CMD_HALT;
               end
               else if (evt_pend)
                  state <= bwsf_pkg::S_COUNT;
               else if (await_pend)
               begin
                  state <= bwsf_pkg::S_CMD;
                  cmd_code <= bwsf_pkg::CMD_AWAIT;
               end
               else if (rel_pend)
                  state <= bwsf_pkg::S_RELEASE;
            end
            bwsf_pkg::S_COUNT:
            begin
               if (xfer_done)
               begin
                  xfer_count <= count_cap;
                  // the device stops itself at the limit
                  state <= limit_hit ? bwsf_pkg::S_IDLE : bwsf_pkg::S_RUN;
               end
            end
            bwsf_pkg::S_RELEASE:
            begin
               if (xfer_done)
                  state <= bwsf_pkg::S_RUN;
            end
            default: state <= bwsf_pkg::S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   req_hold_a: assert property (dev_req && !ack_s |=> dev_req && $stable(dev_addr))
      else $error("device request dropped before acknowledge");
   slots_all_a: assert property (state == bwsf_pkg::S_CMD && $past(state) == bwsf_pkg::S_SETUP
      |-> $past(step) == ring_qty[8:0] + 9'h002)
      else $error("start issued before every slot address was written");
   start_gate_a: assert property ($rose(state == bwsf_pkg::S_SETUP) |-> $past(all_filled))
      else $error("stream started with unfilled buffers");
   qty_range_a: assert property (state == bwsf_pkg::S_SETUP |-> ring_qty >= 32'h00000002 &&
      ring_qty <= 32'h00000100)
      else $error("ring quantity out of range during setup");
   len_align_a: assert property (state == bwsf_pkg::S_SETUP |-> ring_len[9:0] == 10'h000)
      else $error("buffer length not a multiple of 1024");
   start_block_a: assert property (state == bwsf_pkg::S_CMD && xfer_done &&
      cmd_code == bwsf_pkg::CMD_START_BLOCK |=> state == bwsf_pkg::S_WAIT)
      else $error("blocking start did not wait");
   wait_hold_a: assert property (state == bwsf_pkg::S_WAIT && !evt_pend && !halt_pend
      |=> state == bwsf_pkg::S_WAIT)
      else $error("wait left without next-buffer event");
   halt_wait_a: assert property (state == bwsf_pkg::S_WAIT && halt_pend |=>
      state == bwsf_pkg::S_CMD && cmd_code == bwsf_pkg::CMD_HALT ##1 dev_req &&
      dev_addr == bwsf_pkg::DEV_CMD_REG && dev_wdata == 32'h00000014)
      else $error("halt not issued from wait");
   release_fwd_a: assert property (state == bwsf_pkg::S_RELEASE && $rose(dev_req) |->
      dev_addr == 16'hEA92 && dev_wdata == {24'h000000, $past(rel_idx)})
      else $error("release index not forwarded");
   auto_stop_a: assert property (state == bwsf_pkg::S_COUNT && xfer_done && limit_hit
      |=> idle && done_flag && xfer_count >= stop_limit)
      else $error("limit reached without stop");

   wait_seen_c: cover property (state == bwsf_pkg::S_WAIT ##[1:1000] state == bwsf_pkg::S_COUNT);
   auto_stop_c: cover property (state == bwsf_pkg::S_COUNT && xfer_done && limit_hit);
   halt_wait_c: cover property (state == bwsf_pkg::S_WAIT && halt_pend);
   release_c: cover property (state == bwsf_pkg::S_RELEASE && xfer_done);
endmodule
`default_nettype wire

// *** logic/bwsf_pkg.sv ***
`default_nettype none
package bwsf_pkg;
   // ----------------------------------------------------------------
   // device register numbers, driven on dev_addr
   // ----------------------------------------------------------------
   localparam logic [15:0] DEV_CMD_REG = 16'h0000;
   localparam logic [15:0] DEV_QTY_REG = 16'hEA60;
   localparam logic [15:0] DEV_LEN_REG = 16'hEA6A;
   localparam logic [15:0] DEV_COUNT_REG = 16'hEA74;
   localparam logic [15:0] DEV_LIMIT_REG = 16'hEA7E;
   localparam logic [15:0] DEV_RELEASE_REG = 16'hEA92;
   localparam logic [15:0] DEV_SLOT_BASE = 16'hEAC4;
   localparam logic [31:0] CMD_START_BLOCK = 32'h0000000C;
   localparam logic [31:0] CMD_AWAIT = 32'h0000000D;
   localparam logic [31:0] CMD_START_NOWAIT = 32'h0000000E;
   localparam logic [31:0] CMD_HALT = 32'h00000014;
   localparam logic [31:0] QTY_MIN = 32'h00000002;
   localparam logic [31:0] QTY_MAX = 32'h00000100;
   localparam int LEN_ALIGN_BITS = 10;
   localparam logic [31:0] QTY_RST = 32'h00000002;
   localparam logic [31:0] LEN_RST = 32'h00000400;
   localparam logic [31:0] LIMIT_RST = 32'h00000000;
   // ----------------------------------------------------------------
   // own register word indices (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [9:0] A_CTRL = 10'h000;
   localparam logic [9:0] A_STATUS = 10'h001;
   localparam logic [9:0] A_QTY = 10'h002;
   localparam logic [9:0] A_LEN = 10'h003;
   localparam logic [9:0] A_LIMIT = 10'h004;
   localparam logic [9:0] A_COUNT = 10'h005;
   localparam logic [9:0] A_RELEASE = 10'h006;
   localparam logic [9:0] A_LAYOUT = 10'h007;
   localparam logic [9:0] A_LAYOUT_OFF = 10'h008;
   localparam logic [1:0] A_SLOT_PAGE = 2'h1;
   localparam int CTRL_START_BLOCK = 0;
   localparam int CTRL_START_NOWAIT = 1;
   localparam int CTRL_AWAIT = 2;
   localparam int CTRL_HALT = 3;
   typedef enum {S_IDLE, S_SETUP, S_CMD, S_WAIT, S_RUN, S_COUNT, S_RELEASE} bwsf_state_t;
endpackage
`default_nettype wire

// *** tb/bwsf_dev_model.sv ***
`default_nettype none
module bwsf_dev_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic dev_req,
   input wire logic dev_we,
   input wire logic [15:0] dev_addr,
   input wire logic [31:0] dev_wdata,
   input wire logic fire,
   input wire logic slow,
   output logic dev_ack,
   output logic [31:0] dev_rdata,
   output logic dev_next_buf,
   output logic [31:0] last_cmd,
   output logic [31:0] last_rel
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] limit;
   logic [31:0] count;
   logic run;
   logic [2:0] hold;
   logic [1:0] tick;
   // held four clocks, above the one-clock minimum the host needs
   assign dev_next_buf = (hold != 3'h0);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {dev_ack, run, hold, tick} <= '0;
         {dev_rdata, limit, count, last_cmd, last_rel} <= '0;
      end
      else
      begin
         tick <= tick + 2'h1;
         hold <= (hold != 3'h0) ? hold - 3'h1 : 3'h0;
         // released data toggles so a stale capture cannot pass
         dev_rdata <= ~dev_rdata;
         if (!dev_req)
            dev_ack <= 1'b0;
         else if (dev_ack)
            dev_rdata <= dev_rdata;
         else if (!slow || tick == 2'h0)
         begin
            dev_ack <= 1'b1;
            dev_rdata <= (dev_addr == bwsf_pkg::DEV_COUNT_REG) ? count : 32'h0;
            if (dev_we && dev_addr == bwsf_pkg::DEV_LIMIT_REG)
               limit <= dev_wdata;
            if (dev_we && dev_addr == bwsf_pkg::DEV_RELEASE_REG)
               last_rel <= dev_wdata;
            if (dev_we && dev_addr == bwsf_pkg::DEV_CMD_REG)
               last_cmd <= dev_wdata;
            if (dev_we && dev_addr == bwsf_pkg::DEV_CMD_REG &&
               (dev_wdata == bwsf_pkg::CMD_START_BLOCK || dev_wdata == bwsf_pkg::CMD_START_NOWAIT))
            begin
               run <= 1'b1;
               count <= 32'h0;
            end
            if (dev_we && dev_addr == bwsf_pkg::DEV_CMD_REG && dev_wdata == 32'h14)
               run <= 1'b0;
         end
         if (fire && run && hold == 3'h0)
         begin
            hold <= 3'h4;
            count <= count + 32'h1;
            if (limit != 32'h0 && count + 32'h1 >= limit)
               run <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/bwsf_host_ctrl_tb.sv ***
`default_nettype none
module bwsf_host_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic fire = 1'b0;
   logic slow = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, dev_req, dev_we, dev_ack, dev_next_buf;
   logic [31:0] hrdata, dev_wdata, dev_rdata, last_cmd, last_rel;
   logic [15:0] dev_addr;
   int miscompares = 0;
   int samples_checked = 0;
   always #4 hclk = ~hclk;
   bwsf_host_ctrl i_bwsf_host_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .dev_req, .dev_we, .dev_addr,
      .dev_wdata, .dev_ack, .dev_rdata, .dev_next_buf);
   bwsf_dev_model i_bwsf_dev_model (.hclk, .hresetn, .dev_req, .dev_we, .dev_addr, .dev_wdata,
      .fire, .slow, .dev_ack, .dev_rdata, .dev_next_buf, .last_cmd, .last_rel);
   // ------
   // bus helpers
   // ------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic poll(input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] r;
      for (int i = 0; i < 300; i++)
      begin
         bus(1'b0, 32'h4, 32'h0, r);
         if ((r & mask) === exp)
            break;
      end
      chk(r & mask, exp);
   endtask
   task automatic wcmd(input logic [31:0] exp);
      for (int i = 0; i < 300 && last_cmd !== exp; i++)
         @(posedge hclk);
      chk(last_cmd, exp);
   endtask
   task automatic pulse;
      @(posedge hclk);
      fire <= 1'b1;
      @(posedge hclk);
      fire <= 1'b0;
   endtask
   task automatic setup(input logic [31:0] lim);
      wr(32'h10, lim);
      wr(32'h400, 32'h1000);
      wr(32'h404, 32'h2000);
      wr(32'h18, 32'h0);
      wr(32'h18, 32'h1);
   endtask
   task automatic t_reset;
      rdc(32'h4, 32'h0);
      rdc(32'h14, 32'h0);
      rdc(32'h8, 32'h2);
      rdc(32'hC, 32'h400);
      rdc(32'h10, 32'h0);
      rdc(32'h40, 32'h0);
      wr(32'h0, 32'h1);
      poll(32'h11, 32'h10);
      $display("reset test done");
   endtask
   task automatic t_block;
      setup(32'h2);
      rdc(32'h404, 32'h2000);
      wr(32'h0, 32'h1);
      wcmd(bwsf_pkg::CMD_START_BLOCK);
      poll(32'h2, 32'h2);
      pulse();
      poll(32'h2, 32'h0);
      pulse();
      poll(32'h9, 32'h8);
      rdc(32'h14, 32'h2);
      $display("blocking start test done");
   endtask
   task automatic t_nowait;
      setup(32'h0);
      slow <= 1'b1;
      wr(32'h0, 32'h2);
      wcmd(bwsf_pkg::CMD_START_NOWAIT);
      poll(32'h6, 32'h4);
      wr(32'h0, 32'h4);
      wcmd(bwsf_pkg::CMD_AWAIT);
      poll(32'h2, 32'h2);
      pulse();
      poll(32'h2, 32'h0);
      wr(32'h18, 32'h1);
      for (int i = 0; i < 300 && last_rel !== 32'h1; i++)
         @(posedge hclk);
      chk(last_rel, 32'h1);
      rdc(32'h14, 32'h1);
      wr(32'h0, 32'h4);
      poll(32'h2, 32'h2);
      wr(32'h0, 32'h8);
      wcmd(bwsf_pkg::CMD_HALT);
      poll(32'h1, 32'h0);
      slow <= 1'b0;
      $display("no-wait start test done");
   endtask
   task automatic t_layout;
      logic [31:0] q[11] = '{32'h5, 32'h50000003, 32'h80000002, 32'h90000002, 32'hA0000002,
         32'hB0000002, 32'hC0000010, 32'hD0000010, 32'hE0000010, 32'h40000003, 32'hF0000010};
      logic [31:0] e[11] = '{32'h5, 32'h7, 32'h8, 32'hA, 32'h9, 32'hB, 32'h2, 32'h4, 32'h8,
         32'h6, 32'h10};
      for (int i = 0; i < 11; i++)
      begin
         wr(32'h1C, q[i]);
         rdc(32'h20, e[i]);
      end
      $display("layout test done");
   endtask
   task automatic report_and_stop;
      $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_block();
      t_nowait();
      t_layout();
      report_and_stop();
   end
   // about sixty times the longest expected run
   initial
   begin
      #200000;
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
